/* rtl/host_port_pkg.sv */
// constants for the dual-channel host bus port
// assumes one synchronous clock domain; strap and pins already synchronous
package host_port_pkg;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 3;
   localparam int          MCR_IRQ_BIT  = 3;
   localparam logic [7:0]  MCR_RESET    = 8'h00;
   localparam logic [2:0]  MCR_OFFSET   = 3'h4;
   localparam logic        CHAN_A       = 1'b0;
   localparam logic        CHAN_B       = 1'b1;
   localparam logic        STRAP_STROBE = 1'b1;
endpackage : host_port_pkg

/* rtl/edge_sense.sv */
// falling and rising edge detector for one synchronous active-low strobe
// assumes the strobe is already synchronous to ref_clk
`timescale 1ns/1ps
module edge_sense
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic level_n,
   output wire logic fall,
   output wire logic rise
);
   logic prev_n;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         prev_n <= 1'b1;
      else
         prev_n <= level_n;
   end

   assign fall = prev_n & ~level_n;
   assign rise = ~prev_n & level_n;
endmodule : edge_sense

/* rtl/duart_host_bus_port.sv */
// host bus port of a dual uart: bus style decode, register strobes, irq pins
// assumes synchronous pins; channel logic sits behind the strobe ports
//
// Summary of operation
// - strap high strobe style, low rw style
// - strobe mode: read starts on falling edge
// - strobe mode: write loads on rising edge
// - rw mode ignores the read strobe
// - rw mode: write pin high read, low write
// - strobe mode: two selects pick channel
// - rw mode: one select, second pin picks channel
// - three address lines pick the register
// - eight bit bus, driven only on reads
// - strobe mode irq driven when modem bit set
// - rw mode: one shared open-drain low irq
// - strobe mode: channel b irq gated by its own bit
`timescale 1ns/1ps
module duart_host_bus_port
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       bus_style,
   input  wire logic       read_strobe_n,
   input  wire logic       write_strobe_n,
   input  wire logic       chan_a_select_n,
   input  wire logic       chan_b_select_n,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output wire logic       data_oe,
   output logic            reg_rd,
   output logic            reg_wr,
   output logic            reg_chan,
   output logic      [2:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] rdata_a,
   input  wire logic [7:0] rdata_b,
   input  wire logic [7:0] modem_control_reg_a,
   input  wire logic [7:0] modem_control_reg_b,
   input  wire logic       irq_req_a,
   input  wire logic       irq_req_b,
   output wire logic       chan_a_irq,
   output wire logic       chan_a_irq_oe,
   output wire logic       chan_b_irq,
   output wire logic       chan_b_irq_oe,
   output wire logic       aux_output_2_a_n,
   output wire logic       aux_output_2_b_n
);
   ////////////////////////////////////////////////////////////////////////
   // decode helpers
   // applicable select for the strapped style
   function automatic logic sel_any
   (
      input logic strobe,
      input logic a_n,
      input logic b_n
   );
      if (strobe)
         return ~a_n | ~b_n;
      else
         return ~a_n;
   endfunction : sel_any

   // channel chosen; both selects low in strobe style gives channel a
   function automatic logic sel_chan
   (
      input logic strobe,
      input logic a_n,
      input logic b_n
   );
      if (strobe)
         return a_n ? host_port_pkg::CHAN_B : host_port_pkg::CHAN_A;
      else
         return b_n;
   endfunction : sel_chan

   // active-low strobe level as seen by the edge detectors
   function automatic logic style_level_n
   (
      input logic strobe,
      input logic pin_n,
      input logic rw_req
   );
      if (strobe)
         return pin_n;
      else
         return ~rw_req;
   endfunction : style_level_n

   // read byte of the chosen channel
   function automatic logic [7:0] chan_byte
   (
      input logic       chan,
      input logic [7:0] byte_a,
      input logic [7:0] byte_b
   );
      if (chan == host_port_pkg::CHAN_B)
         return byte_b;
      else
         return byte_a;
   endfunction : chan_byte

   ////////////////////////////////////////////////////////////////////////
   // bus style and decode
   wire logic strobe_mode = (bus_style == host_port_pkg::STRAP_STROBE);
   // rw style: write pin doubles as direction, read strobe ignored
   wire logic rw_sel      = ~strobe_mode & ~chan_a_select_n;
   wire logic any_sel     = sel_any(strobe_mode, chan_a_select_n,
                                    chan_b_select_n);
   // both selects low in strobe mode: channel a wins
   wire logic pick_chan   = sel_chan(strobe_mode, chan_a_select_n,
                                     chan_b_select_n);
   wire logic rd_level_n  = style_level_n(strobe_mode, read_strobe_n,
                              rw_sel & write_strobe_n);
   wire logic wr_level_n  = style_level_n(strobe_mode, write_strobe_n,
                              rw_sel & ~write_strobe_n);

   wire logic rd_fall;
   wire logic rd_rise;
   wire logic wr_fall;
   wire logic wr_rise;

   edge_sense rd_edge
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .level_n (rd_level_n),
      .fall    (rd_fall),
      .rise    (rd_rise)
   );

   edge_sense wr_edge
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .level_n (wr_level_n),
      .fall    (wr_fall),
      .rise    (wr_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // transaction tracking
   logic rd_active;
   logic wr_active;
   logic wr_chan;
   logic [2:0] wr_addr;

   // rw style has no rising strobe: write loads when select releases
   wire logic do_read  = rd_fall & any_sel;
   wire logic do_write = wr_active & wr_rise;
   wire logic [7:0] rd_pick = chan_byte(pick_chan, rdata_a, rdata_b);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rd_active <= 1'b0;
      else if (do_read)
         rd_active <= 1'b1;
      else if (rd_rise || !any_sel)
         rd_active <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_active <= 1'b0;
         wr_chan   <= host_port_pkg::CHAN_A;
         wr_addr   <= '0;
      end
      else if (wr_fall && any_sel)
      begin
         wr_active <= 1'b1;
         wr_chan   <= pick_chan;
         wr_addr   <= addr;
      end
      else if (wr_rise)
         wr_active <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         reg_rd    <= 1'b0;
         reg_wr    <= 1'b0;
         reg_chan  <= host_port_pkg::CHAN_A;
         reg_addr  <= '0;
         reg_wdata <= '0;
         data_out  <= '0;
      end
      else
      begin
         reg_rd <= do_read;
         reg_wr <= do_write;
         if (do_read)
         begin
            reg_chan <= pick_chan;
            reg_addr <= addr;
         end
         else if (do_write)
         begin
            reg_chan  <= wr_chan;
            reg_addr  <= wr_addr;
            reg_wdata <= data_in;
         end
         if (rd_active || do_read)
            data_out <= rd_pick;
      end
   end

   // drive only while a selected read is open
   assign data_oe = rd_active & any_sel & ~rd_level_n;

   ////////////////////////////////////////////////////////////////////////
   // interrupt pins
   wire logic irq_en_a = modem_control_reg_a[host_port_pkg::MCR_IRQ_BIT];
   wire logic irq_en_b = modem_control_reg_b[host_port_pkg::MCR_IRQ_BIT];
   wire logic shared_irq = irq_req_a | irq_req_b;

   // open drain in rw style only: drives low, pull-up is external; strobe style drives irq_req_a and irq_req_b high and low
   assign chan_a_irq    = strobe_mode ? irq_req_a : 1'b0;
   assign chan_a_irq_oe = strobe_mode ? irq_en_a : shared_irq;
   assign chan_b_irq    = irq_req_b;
   assign chan_b_irq_oe = strobe_mode & irq_en_b;
   assign aux_output_2_a_n = ~irq_en_a;
   assign aux_output_2_b_n = ~irq_en_b;
endmodule : duart_host_bus_port

/* test/chan_model.sv */
// channel registers behind the host port
// assumes reg_wr pulses from duart_host_bus_port
`timescale 1ns/1ps
module chan_model
(
   input  wire logic       ref_clk,
   input  wire logic       reg_wr,
   input  wire logic       reg_chan,
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output wire logic [7:0] rdata_a,
   output wire logic [7:0] rdata_b,
   output wire logic [7:0] modem_control_reg_a,
   output wire logic [7:0] modem_control_reg_b
);
   // no reset pin: contents start at the modem control reset value
   logic [7:0] mem [2][8] = '{default: 8'h00};
   assign rdata_a = mem[0][reg_addr];
   assign rdata_b = mem[1][reg_addr];
   assign modem_control_reg_a = mem[0][3'h4];
   assign modem_control_reg_b = mem[1][3'h4];
   ////////////////////////////////////////
   always @(posedge ref_clk)
      if (reg_wr)
         mem[reg_chan][reg_addr] <= reg_wdata;
endmodule : chan_model

/* test/port_props.sv */
// strobe and select assertions
// assumes binding to duart_host_bus_port
`timescale 1ns/1ps
module port_props
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic bus_style,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chan_a_select_n,
   input wire logic chan_b_select_n,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic reg_chan
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_rd_start: assert property ($fell(read_strobe_n)
      && bus_style && !(chan_a_select_n && chan_b_select_n)
      |=> reg_rd && reg_chan == $past(chan_a_select_n)) else $error("rd");
   chk_rw_read: assert property ($fell(chan_a_select_n)
      && !bus_style && write_strobe_n
      |=> reg_rd && reg_chan == $past(chan_b_select_n)) else $error("rw");
   chk_wr_start: assert property ($rose(write_strobe_n)
      && bus_style && !$past(chan_a_select_n)
      |=> reg_wr && !reg_chan) else $error("wr");
   chk_rw_write: assert property ($rose(chan_a_select_n)
      && !bus_style && !$past(write_strobe_n)
      |-> ##[1:2] reg_wr) else $error("rww");
   chk_no_select: assert property (bus_style && chan_a_select_n
      && chan_b_select_n |=> !reg_rd) else $error("sel");
   chk_rw_dir: assert property (!bus_style && !write_strobe_n
      |=> !reg_rd) else $error("dir");
   chk_rd_once: assert property (reg_rd |=> !reg_rd)
      else $error("rd1");
   chk_wr_once: assert property (reg_wr |=> !reg_wr)
      else $error("wr1");
   cover property (reg_rd && reg_chan);
   cover property (reg_wr && !bus_style);
   cover property (reg_rd && !bus_style);
endmodule : port_props
////////////////////////////////////////
bind duart_host_bus_port port_props port_props_inst (.*);

/* test/duart_host_bus_port_tb.sv */
// random and corner accesses in both bus styles
// assumes chan_model holds the channel registers
`timescale 1ns/1ps
module duart_host_bus_port_tb;
   logic ref_clk = 0, rst = 1, bus_style = 1, read_strobe_n = 1;
   logic write_strobe_n = 1, chan_a_select_n = 1, chan_b_select_n = 1;
   logic irq_req_a = 0, irq_req_b = 0, data_oe, reg_rd, reg_wr, reg_chan;
   logic chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe;
   logic aux_output_2_a_n, aux_output_2_b_n;
   logic [2:0] addr = 3'h0, reg_addr;
   logic [7:0] data_in = 8'h00, data_out, reg_wdata, rdata_a, rdata_b;
   logic [7:0] modem_control_reg_a, modem_control_reg_b;
   logic [7:0] sh [2][8] = '{default: 8'h00};
   logic [31:0] seed = 32'h0001_1a2c;
   int fails = 0, tests_run = 0;
   duart_host_bus_port duart_host_bus_port_inst (.*);
   chan_model chan_model_inst (.*);
   always #12.5 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   function logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task chk(string n, logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task stop_test;
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   // s style, c channel, w write, g no select at all
   task acc(logic s, c, w, g, logic [2:0] a, logic [7:0] d);
      @(posedge ref_clk);
      bus_style <= s;
      {irq_req_a, irq_req_b} <= seed[7:6];
      @(posedge ref_clk);
      {addr, data_in} <= {a, d};
      chan_a_select_n <= g | s & c;
      chan_b_select_n <= g | s ^ c;
      {read_strobe_n, write_strobe_n} <= {s ? w : seed[5], !w};
      repeat (5) @(posedge ref_clk);
      #1;
      if (!w) chk("oe", data_oe, !g);
      if (!w && !g) chk("rd", data_out, sh[c][a]);
      @(posedge ref_clk);
      {read_strobe_n, write_strobe_n} <= 2'h3;
      {chan_a_select_n, chan_b_select_n} <= 2'h3;
      if (w && !g) sh[c][a] = d;
      #1 chk("off", data_oe, 0);
      repeat (4) @(posedge ref_clk);
      #1 chk("irq", {chan_b_irq_oe, aux_output_2_a_n, chan_a_irq_oe,
         chan_a_irq}, {s & sh[1][4][3], !sh[0][4][3],
         s ? {sh[0][4][3], irq_req_a} : {irq_req_a | irq_req_b, 1'b0}});
      chk("irqb", {chan_b_irq, aux_output_2_b_n}, {irq_req_b, !sh[1][4][3]});
   endtask : acc
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      acc(1'b1, 1'b1, 1'b1, 1'b0, 3'h4, 8'h08);
      acc(1'b0, 1'b0, 1'b1, 1'b0, 3'h4, 8'hff);
      for (int i = 0; i < 300; i++)
      begin
         seed = lfsr(seed);
         acc(seed[0], seed[1], seed[2], seed[3] & seed[4], seed[10:8],
             seed[23:16]);
      end
      stop_test;
   end
   // hang guard, well beyond the length of the access loop
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      stop_test;
   end
endmodule : duart_host_bus_port_tb
